// ==== program_flash_block_writer.sv ====
// Notes on behaviour
// RL1: Program whole 8 or 16 byte blocks only.
// RL2: Core loads one byte per table store.
// RL3: Table stores only fill holding registers.
// RL4: One holding register per block byte.
// RL5: Stall the core during a long write.
// RL6: Internal timer ends the long write.
// RL7: Holding registers preset FFh on reset, after write.
// RL8: FFh holding byte leaves flash byte unchanged.
// RL9: Software selects program memory and enables write.
// RL10: Unlock needs 55h then AAh before start.
// RL11: Start after unlock launches the block write.
// RL12: Core stalls about 2 ms for the write.
// RL13: Software loads from first byte, pointer increments.
// RL14: Software erases 64-byte region before programming.
// RL15: Table pointer stays inside the target block.
// RL16: Software verifies by table reads afterwards.
// RL17: Software masks interrupts across the unlock sequence.
// RL18: Ignore start without unlock or enable.
`timescale 1ns/1ps
`default_nettype none

module program_flash_block_writer #(
  parameter int unsigned BLOCK_BYTES = flash_writer_pkg::BLOCK_BYTES_DEFAULT,
  parameter int unsigned ADDR_BITS = flash_writer_pkg::ADDR_BITS_DEFAULT,
  parameter int unsigned WRITE_CYCLES = flash_writer_pkg::WRITE_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic table_store_instruction,
  input wire logic [7:0] table_byte_latch,
  input wire logic [ADDR_BITS-1:0] table_pointer,
  input wire logic memory_target_select,
  input wire logic config_space_select,
  input wire logic program_enable_bit,
  input wire logic unlock_write,
  input wire logic [7:0] unlock_data,
  input wire logic start_write,
  output logic core_stall,
  output logic write_busy,
  output logic write_done,
  output logic flash_wr_en,
  output logic [ADDR_BITS-1:0] flash_addr,
  output logic [7:0] flash_wdata,
  output logic [BLOCK_BYTES-1:0] holding_loaded
);

  localparam int unsigned IDX_BITS = $clog2(BLOCK_BYTES);
  localparam int unsigned CNT_BITS = $clog2(WRITE_CYCLES + 1);
  localparam logic [CNT_BITS-1:0] CNT_LAST = CNT_BITS'(WRITE_CYCLES - 1);

  logic [7:0] hold_reg [BLOCK_BYTES];
  flash_writer_pkg::unlock_state_t unlock_reg;
  logic [CNT_BITS-1:0] timer_reg;
  logic [IDX_BITS:0] prog_idx_reg;
  logic [ADDR_BITS-IDX_BITS-1:0] block_base_reg;
  logic launch;
  logic timer_end;

  function automatic logic [IDX_BITS-1:0] byte_index(input logic [ADDR_BITS-1:0] addr);
    byte_index = addr[IDX_BITS-1:0];
  endfunction : byte_index

  ////////////////////////////////////////////////////////////////////////////
  // Unlock sequence: any write to the port other than the expected byte
  // drops back to idle, and any start attempt consumes the arming.

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      unlock_reg <= flash_writer_pkg::UNLOCK_IDLE;
    end else if (start_write || write_busy) begin
      unlock_reg <= flash_writer_pkg::UNLOCK_IDLE; // RL18
    end else if (unlock_write) begin
      unique case (unlock_reg)
        flash_writer_pkg::UNLOCK_IDLE: begin
          unlock_reg <= (unlock_data == flash_writer_pkg::UNLOCK_FIRST) ?
                        flash_writer_pkg::UNLOCK_HALF : flash_writer_pkg::UNLOCK_IDLE; // RL10
        end
        flash_writer_pkg::UNLOCK_HALF: begin
          unlock_reg <= (unlock_data == flash_writer_pkg::UNLOCK_SECOND) ?
                        flash_writer_pkg::UNLOCK_ARMED : flash_writer_pkg::UNLOCK_IDLE; // RL10
        end
        flash_writer_pkg::UNLOCK_ARMED: begin
          unlock_reg <= flash_writer_pkg::UNLOCK_IDLE;
        end
        default: begin
          unlock_reg <= flash_writer_pkg::UNLOCK_IDLE;
        end
      endcase
    end
  end

  assign launch = start_write && !write_busy && program_enable_bit && memory_target_select
                  && !config_space_select
                  && (unlock_reg == flash_writer_pkg::UNLOCK_ARMED); // RL11 RL18
  assign timer_end = write_busy && (timer_reg == CNT_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Holding registers: one per block byte, indexed by the low pointer bits.

  for (genvar g = 0; g < BLOCK_BYTES; g++) begin : g_hold
    always_ff @(posedge clock) begin
      if (sys_rst || timer_end) begin
        hold_reg[g] <= flash_writer_pkg::HOLD_RESET; // RL7 RL4
        holding_loaded[g] <= 1'b0;
      end else if (table_store_instruction && !write_busy
                   && byte_index(table_pointer) == IDX_BITS'(g)) begin
        hold_reg[g] <= table_byte_latch; // RL2 RL3
        holding_loaded[g] <= 1'b1;
      end
    end

    a_unloaded_preset: assert property (@(posedge clock) disable iff (sys_rst) // RL7 RL8
      !holding_loaded[g] |-> hold_reg[g] == flash_writer_pkg::HOLD_RESET)
      else $error("unloaded byte not preset");

    a_store_lands: assert property (@(posedge clock) disable iff (sys_rst) // RL3 RL4
      table_store_instruction && !write_busy && byte_index(table_pointer) == IDX_BITS'(g)
      |=> hold_reg[g] == $past(table_byte_latch) && holding_loaded[g])
      else $error("store missed its byte");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Programming timer and core stall for the long write.

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      write_busy <= 1'b0;
      core_stall <= 1'b0;
      timer_reg <= '0;
      block_base_reg <= '0;
    end else if (launch) begin
      write_busy <= 1'b1;
      core_stall <= 1'b1; // RL5 RL12
      timer_reg <= '0;
      block_base_reg <= table_pointer[ADDR_BITS-1:IDX_BITS]; // RL15
    end else if (timer_end) begin
      write_busy <= 1'b0; // RL6
      core_stall <= 1'b0;
      timer_reg <= '0;
    end else if (write_busy) begin
      timer_reg <= timer_reg + 1'b1; // RL6 RL12
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      write_done <= 1'b0;
    end else begin
      write_done <= timer_end;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte stream to the array: whole block walked, FFh bytes skipped.

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prog_idx_reg <= '0;
      flash_wr_en <= 1'b0;
      flash_addr <= '0;
      flash_wdata <= 8'h00;
    end else begin
      flash_wr_en <= 1'b0;
      if (launch) begin
        prog_idx_reg <= '0; // RL1
      end else if (write_busy && prog_idx_reg < (IDX_BITS+1)'(BLOCK_BYTES)) begin
        prog_idx_reg <= prog_idx_reg + 1'b1;
        flash_addr <= {block_base_reg, prog_idx_reg[IDX_BITS-1:0]};
        flash_wdata <= hold_reg[prog_idx_reg[IDX_BITS-1:0]];
        flash_wr_en <= (hold_reg[prog_idx_reg[IDX_BITS-1:0]] !=
                        flash_writer_pkg::HOLD_RESET); // RL8
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  a_stall_matches_busy: assert property (@(posedge clock) disable iff (sys_rst)
    core_stall == write_busy) else $error("stall differs from busy"); // RL5

  a_launch_sets_stall: assert property (@(posedge clock) disable iff (sys_rst)
    launch |=> core_stall && write_busy) else $error("launch did not stall"); // RL11

  a_no_unarmed_start: assert property (@(posedge clock) disable iff (sys_rst)
    (!write_busy && (unlock_reg != flash_writer_pkg::UNLOCK_ARMED || !program_enable_bit))
    |=> !write_busy) else $error("start without unlock"); // RL18

  a_unlock_order: assert property (@(posedge clock) disable iff (sys_rst)
    (unlock_reg == flash_writer_pkg::UNLOCK_ARMED) |->
    $past(unlock_reg) != flash_writer_pkg::UNLOCK_IDLE) else $error("armed early"); // RL10

  a_timer_ends: assert property (@(posedge clock) disable iff (sys_rst)
    timer_end |=> !write_busy && write_done) else $error("timer did not end"); // RL6

  a_hold_preset: assert property (@(posedge clock) disable iff (sys_rst)
    write_done |-> hold_reg[0] == flash_writer_pkg::HOLD_RESET
    && !holding_loaded[0]) else $error("holding not preset"); // RL7

  a_store_short: assert property (@(posedge clock) disable iff (sys_rst)
    !write_busy |=> !flash_wr_en) else $error("store wrote flash"); // RL3

  a_ff_skipped: assert property (@(posedge clock) disable iff (sys_rst)
    flash_wr_en |-> flash_wdata != flash_writer_pkg::HOLD_RESET) else $error("FFh written"); // RL8

  a_block_stays: assert property (@(posedge clock) disable iff (sys_rst)
    flash_wr_en |-> flash_addr[ADDR_BITS-1:IDX_BITS] == block_base_reg)
    else $error("write left block"); // RL1

  ////////////////////////////////////////////////////////////////////////////
  // Timing of the long write, the byte walk and the unlock arming.
  // These only hold while the write time exceeds the block length.

  a_done_single: assert property (@(posedge clock) disable iff (sys_rst) // RL6
    write_done |=> !write_done)
    else $error("done lasted more than a cycle");

  a_done_after_busy: assert property (@(posedge clock) disable iff (sys_rst) // RL6
    write_done |-> !write_busy && $past(write_busy))
    else $error("done without a write");

  a_busy_holds: assert property (@(posedge clock) disable iff (sys_rst) // RL12
    write_busy && !timer_end |=> write_busy)
    else $error("write ended early");

  a_timer_bounded: assert property (@(posedge clock) disable iff (sys_rst) // RL12
    write_busy |-> timer_reg <= CNT_LAST)
    else $error("timer ran past its end");

  a_timer_idle: assert property (@(posedge clock) disable iff (sys_rst) // RL6
    !write_busy |-> timer_reg == '0)
    else $error("timer not cleared when idle");

  a_timer_steps: assert property (@(posedge clock) disable iff (sys_rst) // RL12
    write_busy && !timer_end |=> timer_reg == $past(timer_reg) + 1'b1)
    else $error("timer skipped a count");

  a_busy_rise: assert property (@(posedge clock) disable iff (sys_rst) // RL11
    $rose(write_busy) |-> $past(launch))
    else $error("write began without launch");

  a_busy_fall: assert property (@(posedge clock) disable iff (sys_rst) // RL6
    $fell(write_busy) |-> $past(timer_end))
    else $error("write ended without timer");

  a_loaded_frozen: assert property (@(posedge clock) disable iff (sys_rst) // RL3
    write_busy && !timer_end |=> $stable(holding_loaded))
    else $error("loaded flags moved during write");

  a_last_frozen: assert property (@(posedge clock) disable iff (sys_rst) // RL3
    write_busy && !timer_end |=> $stable(hold_reg[BLOCK_BYTES-1]))
    else $error("holding byte moved during write");

  a_wr_in_write: assert property (@(posedge clock) disable iff (sys_rst) // RL3
    flash_wr_en |-> $past(write_busy))
    else $error("array written outside a write");

  a_wr_data_held: assert property (@(posedge clock) disable iff (sys_rst) // RL11
    flash_wr_en |-> flash_wdata == hold_reg[flash_addr[IDX_BITS-1:0]])
    else $error("array byte differs from holding byte");

  a_idx_bounded: assert property (@(posedge clock) disable iff (sys_rst) // RL1
    prog_idx_reg <= BLOCK_BYTES)
    else $error("walk index out of range");

  a_walk_start: assert property (@(posedge clock) disable iff (sys_rst) // RL1
    launch |=> prog_idx_reg == '0)
    else $error("walk did not restart");

  a_walk_step: assert property (@(posedge clock) disable iff (sys_rst) // RL1
    write_busy && prog_idx_reg < BLOCK_BYTES |=> prog_idx_reg == $past(prog_idx_reg) + 1'b1)
    else $error("walk skipped a byte");

  a_walk_whole: assert property (@(posedge clock) disable iff (sys_rst) // RL1
    timer_end |-> prog_idx_reg == BLOCK_BYTES)
    else $error("write ended before whole block");

  a_arm_after_half: assert property (@(posedge clock) disable iff (sys_rst) // RL10
    unlock_reg == flash_writer_pkg::UNLOCK_ARMED
    && $past(unlock_reg) != flash_writer_pkg::UNLOCK_ARMED
    |-> $past(unlock_reg) == flash_writer_pkg::UNLOCK_HALF && $past(unlock_write)
    && $past(unlock_data) == flash_writer_pkg::UNLOCK_SECOND)
    else $error("armed without second unlock byte");

  a_half_after_first: assert property (@(posedge clock) disable iff (sys_rst) // RL10
    unlock_reg == flash_writer_pkg::UNLOCK_HALF
    && $past(unlock_reg) != flash_writer_pkg::UNLOCK_HALF
    |-> $past(unlock_write) && $past(unlock_data) == flash_writer_pkg::UNLOCK_FIRST)
    else $error("half armed without first unlock byte");

  a_start_disarms: assert property (@(posedge clock) disable iff (sys_rst) // RL18
    start_write |=> unlock_reg == flash_writer_pkg::UNLOCK_IDLE)
    else $error("start left arming in place");

  a_busy_disarms: assert property (@(posedge clock) disable iff (sys_rst) // RL18
    write_busy |=> unlock_reg == flash_writer_pkg::UNLOCK_IDLE)
    else $error("armed during a write");

  a_select_guard: assert property (@(posedge clock) disable iff (sys_rst) // RL18
    !write_busy && (!memory_target_select || config_space_select) |=> !write_busy)
    else $error("write launched with wrong target");

  a_reset_clean: assert property (@(posedge clock) disable iff (sys_rst) // RL7
    $past(sys_rst) |-> !write_busy && !write_done && !flash_wr_en && holding_loaded == '0)
    else $error("state not cleared by reset");

endmodule : program_flash_block_writer

`default_nettype wire

// ==== flash_writer_pkg.sv ====
package flash_writer_pkg;

  localparam int unsigned CLOCK_HZ = 100_000_000;
  localparam int unsigned WRITE_TIME_US = 2000;
  localparam int unsigned WRITE_CYCLES = WRITE_TIME_US * (CLOCK_HZ / 1_000_000);
  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
  localparam logic [7:0] HOLD_RESET = 8'hFF;
  localparam int unsigned BLOCK_BYTES_DEFAULT = 16;
  localparam int unsigned ADDR_BITS_DEFAULT = 21;

  typedef enum logic [1:0] {
    UNLOCK_IDLE,
    UNLOCK_HALF,
    UNLOCK_ARMED
  } unlock_state_t;

endpackage : flash_writer_pkg

// ==== core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic clock,
  output logic table_store_instruction,
  output logic [7:0] table_byte_latch,
  output logic [20:0] table_pointer,
  output logic memory_target_select,
  output logic config_space_select,
  output logic program_enable_bit,
  output logic unlock_write,
  output logic [7:0] unlock_data,
  output logic start_write
);
  initial begin
    {table_store_instruction, unlock_write, start_write, program_enable_bit} = 4'h0;
    {table_byte_latch, unlock_data, table_pointer, config_space_select, memory_target_select} = 39'h1;
  end
  task automatic op(input logic [1:0] k, input logic [20:0] a, input logic [7:0] d);
    @(posedge clock);
    table_pointer <= a;
    {table_byte_latch, unlock_data} <= {d, d};
    table_store_instruction <= k == 2'h0;
    {unlock_write, start_write} <= {k == 2'h1, k == 2'h2};
    if (k == 2'h3) {config_space_select, memory_target_select, program_enable_bit} <= d[2:0];
    @(posedge clock);
    {table_store_instruction, unlock_write, start_write} <= 3'h0;
    {table_byte_latch, unlock_data} <= ~{d, d};
  endtask : op
  task automatic launch(input logic [20:0] a);
    op(2'h1, a, 8'h55);
    op(2'h1, a, 8'hAA);
    op(2'h2, a, 8'h00);
  endtask : launch
endmodule : core_model
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 1'h0, sys_rst = 1'h1;
  logic table_store_instruction, memory_target_select, config_space_select, start_write;
  logic program_enable_bit, unlock_write, core_stall, write_busy, write_done, flash_wr_en;
  logic [7:0] table_byte_latch, unlock_data, flash_wdata;
  logic [20:0] table_pointer, flash_addr;
  logic [15:0] holding_loaded;
  logic [28:0] wlog[$];
  int mismatches, checks, ns, nd, tick;
  core_model u_core_model (.*);
  program_flash_block_writer #(.WRITE_CYCLES(40)) u_program_flash_block_writer (.*);
  initial forever #5 clock = ~clock;
  always @(posedge clock) begin
    tick++;
    if (flash_wr_en === 1'h1) wlog.push_back({flash_addr, flash_wdata});
    if (core_stall === 1'h1 && write_busy === 1'h1) ns++;
    if (write_done === 1'h1) nd++;
    if (tick == 2000) summarize();
  end
  task automatic check(input logic [95:0] got, input logic [95:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %h, expected %h", $time, got, exp);
    end
  endtask : check
  task automatic summarize;
    if (tick >= 2000) mismatches++;
    if (mismatches == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic sc_refuse;
    u_core_model.launch(21'h100);
    u_core_model.op(2'h3, 21'h100, 8'h07);
    u_core_model.launch(21'h100);
    u_core_model.op(2'h3, 21'h100, 8'h01);
    u_core_model.launch(21'h100);
    u_core_model.op(2'h3, 21'h100, 8'h03);
    u_core_model.op(2'h1, 21'h100, 8'h55);
    u_core_model.op(2'h1, 21'h100, 8'hAB);
    u_core_model.op(2'h2, 21'h100, 8'h00);
    repeat (2) @(posedge clock);
    check(ns, 96'h0);
  endtask : sc_refuse
  task automatic sc_load;
    u_core_model.op(2'h0, 21'h100, 8'h12);
    u_core_model.op(2'h0, 21'h103, 8'h3C);
    u_core_model.op(2'h0, 21'h10F, 8'hA5);
    @(negedge clock);
    check(holding_loaded, 96'h8009);
    check(wlog.size(), 96'h0);
  endtask : sc_load
  task automatic sc_write;
    u_core_model.launch(21'h10F);
    u_core_model.op(2'h0, 21'h102, 8'h77);
    repeat (46) @(posedge clock);
    check(ns, 96'h28);
    check(wlog.size(), 96'h3);
    check({wlog[0], wlog[1], wlog[2]},
      {21'h100, 8'h12, 21'h103, 8'h3C, 21'h10F, 8'hA5});
    check(holding_loaded, 96'h0);
    check(nd, 96'h1);
  endtask : sc_write
  task automatic sc_next;
    u_core_model.op(2'h0, 21'h110, 8'h00);
    u_core_model.op(2'h0, 21'h111, 8'hFF);
    @(negedge clock);
    check(holding_loaded, 96'h3);
    u_core_model.launch(21'h111);
    repeat (46) @(posedge clock);
    check(ns, 96'h50);
    check(nd, 96'h2);
    check({wlog.size(), wlog[3]}, {32'h4, 21'h110, 8'h00});
  endtask : sc_next
  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'h0;
    @(negedge clock);
    check({core_stall, holding_loaded}, 96'h0);
    sc_refuse();
    sc_load();
    sc_write();
    sc_next();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
